// file: bsfs_fet_model.sv
`timescale 1ns/100ps
module bsfs_fet_model import bsfs_pkg::*; (
	// Clock
	input  wire logic             clk_sys,
	// Drive from the block
	input  wire logic             high_side_gate,
	input  wire logic             low_side_gate,
	input  wire logic [REF_W-1:0] soft_start_ref,
	// Bench controls
	input  wire logic             short_cmd,
	input  wire logic [REF_W-1:0] prebias_level,
	// Sensed levels
	output logic                  high_gate_sensed_on = 1'b0,
	output logic                  low_gate_sensed_on = 1'b0,
	output logic                  ramp_above_feedback,
	output logic                  overcurrent_pulse
);
	// ********
	// Switch pair
	// ********

	// Gate charge takes a clock, so the sensed state lags the drive.
	always @(posedge clk_sys) begin
		high_gate_sensed_on <= high_side_gate;
		low_gate_sensed_on  <= low_side_gate;
	end

	// The output holds its pre-bias until the ramp passes it.
	assign ramp_above_feedback = soft_start_ref > prebias_level;

	// A shorted load shows a drop only while the upper switch conducts.
	assign overcurrent_pulse = short_cmd & high_gate_sensed_on;
endmodule

// file: bsfs_pkg.sv
package bsfs_pkg;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int unsigned CLK_KHZ      = 100000;
	localparam int unsigned CLK_NS       = 10;
	localparam int unsigned CAL_US       = 1600;
	localparam int unsigned SS_US        = 4000;
	localparam int unsigned CAL_CYC      = CAL_US * (CLK_KHZ / 1000);
	localparam int unsigned SS_CYC       = SS_US * (CLK_KHZ / 1000);
	localparam int unsigned BLANK_NS     = 100;
	localparam int unsigned BLANK_CYC    = (BLANK_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MAX_DUTY_PCT = 95;
	localparam int unsigned FREQ_LO_KHZ  = 300;
	localparam int unsigned FREQ_HI_KHZ  = 600;

	// ********************************************************
	// Protection
	// ********************************************************
	localparam logic [2:0]  FAULT_LIMIT  = 3'h7;
	localparam logic [2:0]  TIMEOUT_LAST = 3'h6;
	localparam int unsigned REF_W        = 10;
	localparam int unsigned PH_W         = 9;
	localparam int unsigned TMR_W        = 24;

	// Sensed selection current on the error amplifier output.
	localparam logic [1:0]  SENSE_NONE   = 2'h0;
	localparam logic [1:0]  SENSE_LOW_R  = 2'h1;
	localparam logic [1:0]  SENSE_HIGH_R = 2'h2;

	typedef enum logic [1:0] {
		SCL_180MV = 2'h0,
		SCL_105MV = 2'h1,
		SCL_310MV = 2'h2
	} bsfs_scl_e;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_CAL   = 5'h02,
		ST_SOFT  = 5'h04,
		ST_RUN   = 5'h08,
		ST_FAULT = 5'h10
	} bsfs_state_e;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam int unsigned CTRL_INH_BIT = 0;
	localparam logic        CTRL_INH_RST = 1'h0;

endpackage

// file: bsfs_sequencer.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/100ps
module bsfs_sequencer import bsfs_pkg::*; #(
	parameter int unsigned FREQ_KHZ    = FREQ_LO_KHZ,
	parameter int unsigned CAL_CYCLES  = CAL_CYC,
	parameter int unsigned SS_CYCLES   = SS_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// Supply and request
	input  wire logic        undervoltage_lockout,
	input  wire logic        turn_on_req_n,
	// Analog comparators
	input  wire logic        overcurrent_pulse,
	input  wire logic        pwm_demand,
	input  wire logic        ramp_above_feedback,
	input  wire logic [1:0]  comp_sense_level,
	input  wire logic        high_gate_sensed_on,
	input  wire logic        low_gate_sensed_on,
	// Gate and analog control outputs
	output logic             high_side_gate,
	output logic             low_side_gate,
	output logic             oscillator_run,
	output logic             comp_sense_connect,
	output logic [1:0]       short_circuit_limit,
	output logic [REF_W-1:0] soft_start_ref,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	// ********************************************************
	// Derived counts
	// ********************************************************
	localparam int unsigned PER_CYC = CLK_KHZ / FREQ_KHZ;
	localparam int unsigned MAX_ON  = PER_CYC * MAX_DUTY_PCT / 100;
	localparam int unsigned SS_STEP = SS_CYCLES >> REF_W;
	localparam logic [PH_W-1:0]  PER_LAST = PH_W'(PER_CYC - 1);
	localparam logic [REF_W-1:0] REF_MAX  = '1;

	if (FREQ_KHZ != FREQ_LO_KHZ && FREQ_KHZ != FREQ_HI_KHZ) begin
		$error("Switching frequency must be one of two variants.");
	end
	if (SS_CYCLES < (1 << REF_W) || SS_CYCLES >= (1 << TMR_W)) begin
		$error("Soft-start count out of range.");
	end
	if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << TMR_W)) begin
		$error("Calibration count out of range.");
	end

	bsfs_state_e      st_q, st_d;
	logic [PH_W-1:0]  ph_q, hs_fall_q, rect_w_q, win_start;
	logic [TMR_W-1:0] tmr_q, tmr_lim;
	logic [REF_W-1:0] ref_q;
	logic [2:0]       to_q, flt_q;
	logic [1:0]       scl_q;
	logic             term_q, started_q, rect_full_q;
	logic             hs_q, ls_q, inhibit_q;
	logic             go, ph_end, tmr_end, limit_hit, trip, active;
	logic             pulses_ok, hs_cmd, ls_cmd, hs_d, ls_d;
	logic [31:0]      prdata_q;
	logic             pslverr_q;

	// ********************************************************
	// Sequencer
	// ********************************************************
	// A floating request reads high and keeps the converter off.
	assign go = !undervoltage_lockout && !turn_on_req_n
		&& !inhibit_q;
	assign ph_end = (ph_q == PER_LAST);
	assign active = (st_q == ST_SOFT) || (st_q == ST_RUN);
	assign trip = active && (flt_q == FAULT_LIMIT);
	assign tmr_end = (tmr_q == tmr_lim);

	always_comb begin
		tmr_lim = '0;
		case (st_q)
			ST_CAL:   tmr_lim = TMR_W'(CAL_CYCLES - 1);
			ST_SOFT:  tmr_lim = TMR_W'(SS_STEP - 1);
			ST_FAULT: tmr_lim = TMR_W'(SS_CYCLES - 1);
			default:  tmr_lim = '0;
		endcase
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (go)
					st_d = ST_CAL;
			end
			ST_CAL: begin
				if (tmr_end)
					st_d = ST_SOFT;
			end
			ST_SOFT: begin
				if (trip)
					st_d = ST_FAULT;
				else if (tmr_end && ref_q == REF_MAX)
					st_d = ST_RUN;
			end
			ST_RUN: begin
				if (trip)
					st_d = ST_FAULT;
			end
			ST_FAULT: begin
				if (tmr_end && to_q == TIMEOUT_LAST)
					st_d = ST_CAL;
			end
			default: st_d = ST_IDLE;
		endcase
		if (!go)
			st_d = ST_IDLE;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			st_q <= ST_IDLE;
		else
			st_q <= st_d;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			tmr_q <= '0;
		else if (st_d != st_q || tmr_end)
			tmr_q <= '0;
		else
			tmr_q <= tmr_q + 1'b1;
	end

	// The oscillator is frozen during lockout, so no phase advances.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ph_q <= '0;
		else if (undervoltage_lockout || ph_end)
			ph_q <= '0;
		else
			ph_q <= ph_q + 1'b1;
	end

	// ********************************************************
	// Calibration and soft start
	// ********************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			scl_q <= SCL_180MV;
		else if (st_q == ST_CAL && tmr_end) begin
			case (comp_sense_level)
				SENSE_LOW_R:  scl_q <= SCL_105MV;
				SENSE_HIGH_R: scl_q <= SCL_310MV;
				default:      scl_q <= SCL_180MV;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			ref_q <= '0;
		else if (st_q == ST_RUN)
			ref_q <= REF_MAX;
		else if (st_q != ST_SOFT)
			ref_q <= '0;
		else if (tmr_end && ref_q != REF_MAX)
			ref_q <= ref_q + 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			to_q <= '0;
		else if (st_q != ST_FAULT)
			to_q <= '0;
		else if (tmr_end)
			to_q <= to_q + 1'b1;
	end

	// ********************************************************
	// Current limit and fault counter
	// ********************************************************
	assign limit_hit = overcurrent_pulse && hs_q
		&& ph_q >= PH_W'(BLANK_CYC);

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			term_q <= 1'b0;
		else if (ph_end)
			term_q <= 1'b0;
		else if (limit_hit)
			term_q <= 1'b1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			flt_q <= '0;
		else if (!active)
			flt_q <= '0;
		else if (ph_end && (term_q || limit_hit)) begin
			if (flt_q != FAULT_LIMIT)
				flt_q <= flt_q + 1'b1;
		end else if (ph_end && flt_q != 3'h0)
			flt_q <= flt_q - 1'b1;
	end

	// ********************************************************
	// Pre-bias entry of the low side
	// ********************************************************
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			started_q <= 1'b0;
		else if (!active)
			started_q <= 1'b0;
		else if (ramp_above_feedback || st_q == ST_RUN)
			started_q <= 1'b1;
	end

	// Zero until a high-side fall is seen, so the window cannot
	// close at once when pulses begin late in a period.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			hs_fall_q <= '0;
		else if (!active)
			hs_fall_q <= '0;
		else if (hs_q && !hs_d)
			hs_fall_q <= ph_q;
	end

	assign win_start = PER_LAST - rect_w_q;

	// Widening by one clock per period keeps the sink current tiny.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rect_w_q <= '0;
			rect_full_q <= 1'b0;
		end else if (!active) begin
			rect_w_q <= '0;
			rect_full_q <= 1'b0;
		end else if (st_q == ST_RUN)
			rect_full_q <= 1'b1;
		else if (started_q && ph_end && !rect_full_q) begin
			if (win_start <= hs_fall_q)
				rect_full_q <= 1'b1;
			else
				rect_w_q <= rect_w_q + 1'b1;
		end
	end

	// ********************************************************
	// Gate drive
	// ********************************************************
	assign pulses_ok = go && active && started_q
		&& !trip;

	always_comb begin
		hs_cmd = pulses_ok && pwm_demand && !term_q && !limit_hit
			&& ph_q < PH_W'(MAX_ON);
		ls_cmd = 1'b0;
		if (pulses_ok && !hs_cmd) begin
			if (rect_full_q)
				ls_cmd = 1'b1;
			else
				ls_cmd = ph_q >= win_start;
		end
	end

	// Each gate waits for the other to be sensed off before rising.
	assign hs_d = hs_cmd && !ls_q && !low_gate_sensed_on;
	assign ls_d = ls_cmd && !hs_q && !high_gate_sensed_on;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hs_q <= 1'b0;
			ls_q <= 1'b0;
		end else begin
			hs_q <= hs_d;
			ls_q <= ls_d;
		end
	end

	assign high_side_gate = hs_q;
	assign low_side_gate = ls_q;
	assign oscillator_run = !undervoltage_lockout;
	assign comp_sense_connect = (st_q == ST_CAL);
	assign short_circuit_limit = scl_q;
	assign soft_start_ref = ref_q;

	// ********************************************************
	// APB slave
	// ********************************************************
	// Read data is captured in the setup phase so that every
	// access completes without wait states.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
			case (paddr)
				ADDR_CTRL: prdata_q <= {31'h0, inhibit_q};
				ADDR_STATUS: prdata_q <= {10'h0, ref_q, rect_full_q,
					flt_q, started_q, scl_q, st_q};
				default: pslverr_q <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			inhibit_q <= CTRL_INH_RST;
		else if (psel && penable && pwrite && paddr == ADDR_CTRL)
			inhibit_q <= pwdata[CTRL_INH_BIT];
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = pslverr_q;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	chk_lockout_gates: assert property (
		undervoltage_lockout |=> !hs_q && !ls_q && st_q == ST_IDLE)
		else $error("Gates active under lockout.");

	chk_request_idle: assert property (
		turn_on_req_n |=> st_q == ST_IDLE && !hs_q && !ls_q)
		else $error("Withdrawn request did not idle.");

	chk_cal_first: assert property (
		$rose(st_q == ST_SOFT) |-> $past(st_q) == ST_CAL)
		else $error("Soft start without calibration.");

	chk_limit_held: assert property (
		active && $past(active) |-> $stable(scl_q)
		&& !comp_sense_connect)
		else $error("Threshold moved after calibration.");

	chk_ref_full: assert property (
		st_q == ST_RUN |-> ref_q == REF_MAX)
		else $error("Reference not at full in run.");

	chk_limit_cut: assert property (
		limit_hit |=> !hs_q ##1 !hs_q)
		else $error("Pulse survived overcurrent.");

	chk_blank_win: assert property (
		$rose(term_q) |-> $past(ph_q) >= PH_W'(BLANK_CYC))
		else $error("Overcurrent taken in blanking.");

	chk_count_down: assert property (
		active && ph_end && !term_q && !limit_hit && flt_q != 3'h0
		&& st_d == st_q |=> flt_q == $past(flt_q) - 3'h1)
		else $error("Fault counter failed to decrement.");

	chk_fault_off: assert property (
		st_q == ST_FAULT |-> !hs_d && !ls_d)
		else $error("Gate driven during fault timeout.");

	chk_no_overlap: assert property (
		!(hs_q && ls_q))
		else $error("Both gates on together.");

	chk_max_duty: assert property (
		hs_q |-> ph_q <= PH_W'(MAX_ON))
		else $error("High side past duty cap.");

	chk_prebias_low: assert property (
		st_q == ST_SOFT && !started_q |=> !ls_q && !hs_q)
		else $error("Switching before ramp crossed feedback.");

	cov_run: cover property ($rose(st_q == ST_RUN));
	cov_fault: cover property ($rose(st_q == ST_FAULT));
	cov_rect_full: cover property ($rose(rect_full_q) && st_q == ST_SOFT);
	cov_limit_hit: cover property (limit_hit ##1 !hs_q);

endmodule

// file: buck_startup_fault_sequencer_test.sv
`timescale 1ns/100ps
module buck_startup_fault_sequencer_test import bsfs_pkg::*; ();
	// ********
	// Bench state
	// ********
	localparam int unsigned  CAL  = 20;
	localparam int unsigned  SS   = 2048;
	localparam logic [32:0]  M_ST = 33'h1_0000_001f;
	logic                    clk_sys = 1'b0;
	logic                    arst_n = 1'b0;
	logic                    undervoltage_lockout = 1'b1;
	logic                    turn_on_req_n = 1'b1;
	logic                    pwm_demand = 1'b0;
	logic                    short_cmd = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [1:0]              comp_sense_level = 2'h0;
	logic [11:0]             paddr = 12'h000;
	logic [31:0]             pwdata = 32'h0;
	logic [15:0]             rnd_q = 16'h74de;
	logic [REF_W-1:0]        prebias = 10'h200;
	logic [31:0]             prdata;
	logic                    pready, pslverr, oscillator_run;
	logic                    comp_sense_connect, ramp_above_feedback;
	logic                    high_gate_sensed_on, low_gate_sensed_on;
	logic                    overcurrent_pulse;
	logic                    high_side_gate, low_side_gate;
	logic [1:0]              short_circuit_limit;
	logic [REF_W-1:0]        soft_start_ref;
	int                      miscompares = 0;
	int                      compares = 0;
	int                      off_q = 0, hs_len_q = 0, sh_q = 0;
	logic [32:0]             exp_q[$], msk_q[$];
	logic [1:0]              sense_tbl[3] = '{SENSE_NONE, SENSE_LOW_R,
		SENSE_HIGH_R};
	logic [1:0]              lim_tbl[3] = '{SCL_180MV, SCL_105MV, SCL_310MV};

	always #5 clk_sys = ~clk_sys;

	bsfs_sequencer #(.FREQ_KHZ(FREQ_HI_KHZ), .CAL_CYCLES(CAL),
		.SS_CYCLES(SS)) i_dut (.clk_sys, .arst_n, .undervoltage_lockout,
		.turn_on_req_n, .overcurrent_pulse, .pwm_demand,
		.ramp_above_feedback, .comp_sense_level, .high_gate_sensed_on,
		.low_gate_sensed_on, .high_side_gate, .low_side_gate,
		.oscillator_run, .comp_sense_connect, .short_circuit_limit,
		.soft_start_ref, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	bsfs_fet_model i_fet (.clk_sys, .high_side_gate, .low_side_gate,
		.soft_start_ref, .short_cmd, .prebias_level(prebias),
		.high_gate_sensed_on, .low_gate_sensed_on, .ramp_above_feedback,
		.overcurrent_pulse);

	// ********
	// Tasks
	// ********
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Read data is noted here and judged by the bus watcher below.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] exp, input logic [32:0] m);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		if (!wr) begin
			exp_q.push_back(exp);
			msk_q.push_back(m);
		end
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] exp,
		input logic [32:0] m);
		apb(1'b0, a, 32'h0, exp, m);
	endtask

	// ********
	// Watchers
	// ********
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
		if (arst_n) begin
			check(33'(high_side_gate & low_side_gate), 33'h0);
			check(33'((high_side_gate | low_side_gate) &
				(soft_start_ref <= prebias)), 33'h0);
			if (sh_q > 200 && hs_len_q > 0 && high_side_gate === 1'b0)
				check(33'(hs_len_q + 2 >= BLANK_CYC &&
					hs_len_q <= BLANK_CYC + 3), 33'h1);
		end
		off_q      <= (high_side_gate | low_side_gate) ? 0 : off_q + 1;
		hs_len_q   <= high_side_gate ? hs_len_q + 1 : 0;
		sh_q       <= short_cmd ? sh_q + 1 : 0;
		rnd_q      <= lfsr_next(rnd_q);
		pwm_demand <= short_cmd | (|rnd_q[2:0]);
	end

	// A hang is cut short well beyond the longest hiccup cycle.
	initial begin
		repeat (100000) @(posedge clk_sys);
		miscompares++;
		report_and_stop();
	end

	// ********
	// Scenarios
	// ********
	initial begin
		int i;
		int n;
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (2) @(negedge clk_sys);
		check(33'(oscillator_run), 33'h0);
		@(posedge clk_sys);
		undervoltage_lockout <= 1'b0;
		repeat (30) @(posedge clk_sys);
		rd(ADDR_STATUS, 33'h1, M_ST);
		undervoltage_lockout <= 1'b1;
		turn_on_req_n <= 1'b0;
		repeat (30) @(posedge clk_sys);
		rd(ADDR_STATUS, 33'h1, M_ST);
		undervoltage_lockout <= 1'b0;
		turn_on_req_n <= 1'b1;
		for (i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			comp_sense_level <= sense_tbl[i];
			turn_on_req_n <= 1'b0;
			for (n = 0; n < 50 && comp_sense_connect !== 1'b1; n++)
				@(negedge clk_sys);
			for (n = 0; n < 99 && comp_sense_connect === 1'b1; n++)
				@(negedge clk_sys);
			check(33'(n), 33'(CAL));
			@(posedge clk_sys);
			comp_sense_level <= sense_tbl[(i + 1) % 3];
			repeat (8) @(negedge clk_sys);
			check(33'(short_circuit_limit), 33'(lim_tbl[i]));
			check(33'(comp_sense_connect), 33'h0);
			rd(ADDR_STATUS, {26'h0, lim_tbl[i], 5'h04}, 33'h1_0000_007f);
			turn_on_req_n <= 1'b1;
			repeat (3) @(negedge clk_sys);
			check(33'({high_side_gate, low_side_gate}), 33'h0);
			rd(ADDR_STATUS, 33'h1, M_ST);
		end
		turn_on_req_n <= 1'b0;
		for (n = 0; n < 9000 && soft_start_ref !== '1; n++) @(negedge clk_sys);
		repeat (100) @(negedge clk_sys);
		check(33'(soft_start_ref), 33'h3ff);
		rd(ADDR_STATUS, 33'h88, 33'h1_0000_009f);
		short_cmd <= 1'b1;
		for (n = 0; n < 9000 && off_q < 300; n++) @(negedge clk_sys);
		rd(ADDR_STATUS, 33'h10, M_ST);
		short_cmd <= 1'b0;
		for (n = 0; n < 20000 && comp_sense_connect !== 1'b1; n++)
			@(negedge clk_sys);
		check(33'(off_q >= 7 * SS && off_q < 7 * SS + 300), 33'h1);
		rd(ADDR_STATUS, 33'h2, 33'h1_0000_071f);
		apb(1'b1, ADDR_CTRL, 32'h1, 33'h0, 33'h0);
		rd(ADDR_CTRL, 33'h1, 33'h1_ffff_ffff);
		rd(ADDR_STATUS, 33'h1, M_ST);
		rd(12'h008, 33'h1_0000_0000, 33'h1_ffff_ffff);
		apb(1'b1, ADDR_CTRL, 32'h0, 33'h0, 33'h0);
		// Withdraw the request, then assert lockout, while pulses run.
		for (i = 0; i < 2; i++) begin
			for (n = 0; n < 9000 && high_side_gate !== 1'b1; n++)
				@(negedge clk_sys);
			check(33'(high_side_gate), 33'h1);
			@(posedge clk_sys);
			turn_on_req_n <= (i == 0);
			undervoltage_lockout <= (i == 1);
			repeat (2) @(negedge clk_sys);
			check(33'({oscillator_run, high_side_gate, low_side_gate}),
				(i == 0) ? 33'h4 : 33'h0);
			@(posedge clk_sys);
			turn_on_req_n <= 1'b0;
		end
		report_and_stop();
	end
endmodule
